// [hw/omd_decoder.sv]
// memory-region selector and i/o decoder for the on-chip memory map
`timescale 1ns/1ps

// Functional notes
// - top window fe0000h..ffffffh goes to on-chip rom when enabled
// - rom is four 16k-word blocks, 128 kB, chosen by upper bits
// - rom_disable_bit clear (default): top window decoded to rom
// - rom_disable_bit set: rom leaves the map, top window unmapped
// - hardware reset always clears rom_disable_bit
// - software reset instruction leaves rom_disable_bit unchanged
// - rom accepts program bus and data bus accesses
// - each rom block completes one word per cycle, no wait states
// - 010000h..04ffffh maps to single_access_ram, 32 blocks of 4k words
// - each ram block serves one access per cycle; conflicts serialised
// - ram reachable from program, data, dma, usb and lcd buses
// - dma view of ram starts at 0009_0000h, blocks in 8 kB steps
// - last ram block range reserved for bootloader until boot ends
// - separate 64k-word i/o space decoded apart from memory space
// - dma reaches i2c, uart, i2s, sd, usb and converter registers
// - i/o windows by word address: idle, dma, timers, system, usb
// - each dual_access_ram block takes two accesses per cycle
// - usb and lcd masters get no path to dual_access_ram
module omd_decoder
  import omd_pkg::*;
#(
  parameter int NREQ = 2
)(
  input  wire logic                  mclk,
  input  wire logic                  rstn,
  input  wire omd_pkg::omd_req_t     req        [NREQ],
  input  wire logic                  status_reg_3_wr,
  input  wire logic                  status_reg_3_rom_dis,
  input  wire logic                  soft_reset,
  input  wire logic                  boot_done,
  output logic                       grant      [NREQ],
  output omd_pkg::omd_sel_t          sel        [NREQ],
  output logic                       rom_disable_bit,
  output logic                       boot_active
);

  omd_sel_t  dec      [NREQ];
  logic      conflict [NREQ];
  logic      dual     [NREQ];
  logic      busy_blk [NREQ];
  logic [4:0] blk     [NREQ];
  logic      is_sar   [NREQ];
  logic [15:0] io_hit [NREQ];
  logic      rom_dis_r;
  omd_boot_t boot_r;
  logic [NREQ-1:0] rr_r;
  logic [NREQ-1:0] grant_nxt;
  omd_sel_t  sel_r    [NREQ];
  logic      grant_r  [NREQ];

  ////////////////////////////////////////////////////////////////////////
  // rom disable bit

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rom_dis_r <= 1'b0;
    end else if (status_reg_3_wr) begin
      rom_dis_r <= status_reg_3_rom_dis;
    end
    // soft_reset intentionally does not touch this bit
  end

  ////////////////////////////////////////////////////////////////////////
  // boot state: last ram block held for the loader

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      boot_r <= OMD_S_IDLE;
    end else begin
      case (boot_r)
        OMD_S_IDLE: boot_r <= OMD_S_BOOT;
        OMD_S_BOOT: if (boot_done) boot_r <= OMD_S_RUN;
        OMD_S_RUN:  if (soft_reset) boot_r <= OMD_S_BOOT;
        default:    boot_r <= OMD_S_BOOT;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-request address decode

  for (genvar g = 0; g < NREQ; g++) begin : g_dec
    omd_io_decode u_io (
      .io_addr  (req[g].addr[15:0]),
      .from_dma (req[g].master != OMD_M_PROG &&
                 req[g].master != OMD_M_DATA),
      .io_hit   (io_hit[g])
    );

    always_comb begin
      logic        cpu;
      logic [23:0] a24;
      logic [31:0] dofs;
      cpu  = (req[g].master == OMD_M_PROG) || (req[g].master == OMD_M_DATA);
      a24  = req[g].addr[23:0];
      dofs = 32'h0000_0000;
      dec[g]    = '0;
      is_sar[g] = 1'b0;
      blk[g]    = 5'h00;
      dual[g]   = 1'b0;
      if (!req[g].valid) begin
        dec[g].unmapped = 1'b0;
      end else if (req[g].io_space) begin
        dec[g].io_sel = io_hit[g];
      end else if (cpu) begin
        if (a24 >= OMD_ROM_BASE && !rom_dis_r) begin
          dec[g].rom_sel[a24[OMD_ROM_BLK_LSB +: 2]] = 1'b1;
        end else if (a24 >= OMD_SAR_BASE && a24 <= OMD_SAR_LAST) begin
          is_sar[g] = 1'b1;
          blk[g] = 5'((a24 - OMD_SAR_BASE) >> OMD_SAR_BLK_LSB);
        end else if (a24 <= OMD_DAR_LAST) begin
          dec[g].dar_sel = 1'b1;
          dual[g] = 1'b1;
        end
        // top window with rom_disable_bit set falls through unmapped
      end else begin
        if (req[g].addr >= OMD_DSAR_BASE &&
            req[g].addr <= OMD_DSAR_LAST) begin
          dofs = req[g].addr - OMD_DSAR_BASE;
          is_sar[g] = 1'b1;
          blk[g] = dofs[OMD_SAR_BLK_LSB +: 5];
        end else if (req[g].addr >= OMD_DDAR_BASE &&
                     req[g].addr <= OMD_DDAR_LAST &&
                     req[g].master != OMD_M_USB) begin
          dec[g].dar_sel = 1'b1;
          dual[g] = 1'b1;
        end
      end
      // loader-owned block refused to other masters during boot
      if (is_sar[g] && blk[g] == OMD_BOOT_BLK && boot_r != OMD_S_RUN &&
          req[g].master != OMD_M_PROG && req[g].master != OMD_M_DATA)
        is_sar[g] = 1'b0;
      if (is_sar[g])
        dec[g].sar_sel[blk[g]] = 1'b1;
      // io space without a window and unmapped memory select nothing
      if (req[g].valid && dec[g].rom_sel == '0 && dec[g].sar_sel == '0 &&
          !dec[g].dar_sel && dec[g].io_sel == '0)
        dec[g].unmapped = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // single-access conflicts: round-robin between requesters

  always_comb begin
    for (int i = 0; i < NREQ; i++) begin
      conflict[i] = 1'b0;
      busy_blk[i] = 1'b0;
      for (int j = 0; j < NREQ; j++) begin
        if (j != i && req[j].valid && is_sar[i] && is_sar[j] &&
            blk[i] == blk[j] && rr_r[j])
          conflict[i] = 1'b1;
        // rom blocks are single ported too
        if (j != i && req[j].valid && rr_r[j] &&
            (dec[i].rom_sel & dec[j].rom_sel) != '0)
          busy_blk[i] = 1'b1;
      end
      // dual-port blocks never conflict
      grant_nxt[i] = req[i].valid &
                     (dual[i] | ~(conflict[i] | busy_blk[i]));
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rr_r <= NREQ'(1);
    end else if (grant_nxt != '0) begin
      rr_r <= {rr_r[NREQ-2:0], rr_r[NREQ-1]};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered selects: one-cycle access

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < NREQ; i++) begin
        sel_r[i]   <= '0;
        grant_r[i] <= 1'b0;
      end
    end else begin
      for (int i = 0; i < NREQ; i++) begin
        grant_r[i] <= grant_nxt[i];
        sel_r[i]   <= grant_nxt[i] ? dec[i] : '0;
      end
    end
  end

  always_comb begin
    for (int i = 0; i < NREQ; i++) begin
      grant[i] = grant_r[i];
      sel[i]   = sel_r[i];
    end
  end

  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rom_disable_bit <= 1'b0;
      boot_active     <= 1'b1;
    end else begin
      rom_disable_bit <= rom_dis_r;
      boot_active     <= (boot_r != OMD_S_RUN);
    end
  end

endmodule

// [shared/omd_pkg.sv]
// shared constants and types for the on-chip memory map decoder
package omd_pkg;

  // byte-address windows, processor view (24-bit)
  localparam logic [23:0] OMD_ROM_BASE   = 24'hfe0000;
  localparam logic [23:0] OMD_ROM_LAST   = 24'hffffff;
  localparam logic [23:0] OMD_SAR_BASE   = 24'h010000;
  localparam logic [23:0] OMD_SAR_LAST   = 24'h04ffff;
  localparam logic [23:0] OMD_DAR_LAST   = 24'h00ffff;
  localparam logic [23:0] OMD_BOOT_BASE  = 24'h04e000;
  localparam logic [23:0] OMD_BOOT_LAST  = 24'h04efff;
  // byte-address windows, dma/usb/lcd view (32-bit)
  localparam logic [31:0] OMD_DSAR_BASE  = 32'h0009_0000;
  localparam logic [31:0] OMD_DSAR_LAST  = 32'h000c_ffff;
  localparam logic [31:0] OMD_DDAR_BASE  = 32'h0001_0000;
  localparam logic [31:0] OMD_DDAR_LAST  = 32'h0001_ffff;

  // field positions
  localparam int OMD_ROM_BLK_LSB = 15; // 16k words = 32 kB per rom block
  localparam int OMD_SAR_BLK_LSB = 13; // 4k words = 8 kB per ram block
  localparam int OMD_ROM_BLKS    = 4;
  localparam int OMD_SAR_BLKS    = 32;
  localparam logic [4:0] OMD_BOOT_BLK = 5'h1f;

  // i/o word-address windows: base and last
  localparam logic [15:0] OMD_IO_IDLE_B  = 16'h0000;
  localparam logic [15:0] OMD_IO_IDLE_L  = 16'h0004;
  localparam logic [15:0] OMD_IO_DMA_B   = 16'h0c00;
  localparam logic [15:0] OMD_IO_DMA_STP = 16'h0100;
  localparam logic [15:0] OMD_IO_DMA_SZ  = 16'h007f;
  localparam logic [15:0] OMD_IO_TMR_B   = 16'h1800;
  localparam logic [15:0] OMD_IO_TMR_STP = 16'h0040;
  localparam logic [15:0] OMD_IO_TMR_SZ  = 16'h001f;
  localparam logic [15:0] OMD_IO_RTC_B   = 16'h1900;
  localparam logic [15:0] OMD_IO_RTC_L   = 16'h197f;
  localparam logic [15:0] OMD_IO_I2C_B   = 16'h1a00;
  localparam logic [15:0] OMD_IO_I2C_L   = 16'h1a6c;
  localparam logic [15:0] OMD_IO_UART_B  = 16'h1b00;
  localparam logic [15:0] OMD_IO_UART_L  = 16'h1b1f;
  localparam logic [15:0] OMD_IO_SYS_B   = 16'h1c00;
  localparam logic [15:0] OMD_IO_SYS_L   = 16'h1cff;
  localparam logic [15:0] OMD_IO_I2S_B   = 16'h2800;
  localparam logic [15:0] OMD_IO_I2S_SZ  = 16'h0040;
  localparam logic [15:0] OMD_IO_LCD_B   = 16'h2e00;
  localparam logic [15:0] OMD_IO_LCD_L   = 16'h2e40;
  localparam logic [15:0] OMD_IO_SPI_B   = 16'h3000;
  localparam logic [15:0] OMD_IO_SPI_L   = 16'h300f;
  localparam logic [15:0] OMD_IO_SD_B    = 16'h3a00;
  localparam logic [15:0] OMD_IO_SD_L    = 16'h3b7f;
  localparam logic [15:0] OMD_IO_SD_HOLE = 16'h3a80;
  localparam logic [15:0] OMD_IO_SD_HL   = 16'h3aff;
  localparam logic [15:0] OMD_IO_ANA_B   = 16'h7000;
  localparam logic [15:0] OMD_IO_ANA_L   = 16'h70ff;
  localparam logic [15:0] OMD_IO_USB_B   = 16'h8000;

  typedef enum logic [3:0] {
    OMD_M_PROG = 4'h1,
    OMD_M_DATA = 4'h2,
    OMD_M_DMA  = 4'h4,
    OMD_M_USB  = 4'h8   // usb and lcd dma share this class
  } omd_master_t;

  typedef enum logic [4:0] {
    OMD_S_IDLE = 5'h01,
    OMD_S_BOOT = 5'h02,
    OMD_S_RUN  = 5'h04,
    OMD_S_RSV3 = 5'h08,
    OMD_S_RSV4 = 5'h10
  } omd_boot_t;

  // one access request
  typedef struct packed {
    logic        valid;
    omd_master_t master;
    logic        io_space;
    logic        write;
    logic [31:0] addr;
  } omd_req_t;

  // target selects for one accepted access
  typedef struct packed {
    logic [OMD_ROM_BLKS-1:0] rom_sel;
    logic [OMD_SAR_BLKS-1:0] sar_sel;
    logic                    dar_sel;
    logic [15:0]             io_sel;
    logic                    unmapped;
  } omd_sel_t;

  // io window index into io_sel
  localparam int OMD_IO_IDLE = 0;
  localparam int OMD_IO_DMA0 = 1;   // dma0..dma3 at 1..4
  localparam int OMD_IO_TMR0 = 5;   // timer0..2 at 5..7
  localparam int OMD_IO_RTC  = 8;
  localparam int OMD_IO_I2C  = 9;
  localparam int OMD_IO_UART = 10;
  localparam int OMD_IO_SYS  = 11;
  localparam int OMD_IO_I2S  = 12;
  localparam int OMD_IO_SD   = 13;
  localparam int OMD_IO_USB  = 14;
  localparam int OMD_IO_MISC = 15;  // lcd, spi, analog

endpackage

// [hw/omd_io_decode.sv]
// word-address decoder for the 64k-word i/o space
`timescale 1ns/1ps
module omd_io_decode
  import omd_pkg::*;
(
  input  wire logic [15:0] io_addr,
  input  wire logic        from_dma,
  output logic      [15:0] io_hit
);

  logic [15:0] off;

  always_comb begin
    io_hit = 16'h0000;
    off    = 16'h0000;
    if (io_addr <= OMD_IO_IDLE_L)
      io_hit[OMD_IO_IDLE] = 1'b1;
    for (int i = 0; i < 4; i++) begin
      off = io_addr - (OMD_IO_DMA_B + 16'(i) * OMD_IO_DMA_STP);
      if (io_addr >= OMD_IO_DMA_B + 16'(i) * OMD_IO_DMA_STP &&
          off <= OMD_IO_DMA_SZ)
        io_hit[OMD_IO_DMA0 + i] = 1'b1;
    end
    for (int i = 0; i < 3; i++) begin
      off = io_addr - (OMD_IO_TMR_B + 16'(i) * OMD_IO_TMR_STP);
      if (io_addr >= OMD_IO_TMR_B + 16'(i) * OMD_IO_TMR_STP &&
          off <= OMD_IO_TMR_SZ)
        io_hit[OMD_IO_TMR0 + i] = 1'b1;
    end
    if (io_addr >= OMD_IO_RTC_B && io_addr <= OMD_IO_RTC_L)
      io_hit[OMD_IO_RTC] = 1'b1;
    if (io_addr >= OMD_IO_I2C_B && io_addr <= OMD_IO_I2C_L)
      io_hit[OMD_IO_I2C] = 1'b1;
    if (io_addr >= OMD_IO_UART_B && io_addr <= OMD_IO_UART_L)
      io_hit[OMD_IO_UART] = 1'b1;
    if (io_addr >= OMD_IO_SYS_B && io_addr <= OMD_IO_SYS_L)
      io_hit[OMD_IO_SYS] = 1'b1;
    for (int i = 0; i < 4; i++) begin
      off = io_addr - (OMD_IO_I2S_B + 16'(i) * OMD_IO_DMA_STP);
      if (io_addr >= OMD_IO_I2S_B + 16'(i) * OMD_IO_DMA_STP &&
          off <= OMD_IO_I2S_SZ)
        io_hit[OMD_IO_I2S] = 1'b1;
    end
    if (io_addr >= OMD_IO_SD_B && io_addr <= OMD_IO_SD_L &&
        !(io_addr >= OMD_IO_SD_HOLE && io_addr <= OMD_IO_SD_HL))
      io_hit[OMD_IO_SD] = 1'b1;
    if (io_addr >= OMD_IO_USB_B)
      io_hit[OMD_IO_USB] = 1'b1;
    if ((io_addr >= OMD_IO_LCD_B && io_addr <= OMD_IO_LCD_L) ||
        (io_addr >= OMD_IO_SPI_B && io_addr <= OMD_IO_SPI_L) ||
        (io_addr >= OMD_IO_ANA_B && io_addr <= OMD_IO_ANA_L))
      io_hit[OMD_IO_MISC] = 1'b1;
    // dma reaches only the peripheral data windows
    if (from_dma)
      io_hit = io_hit & ((16'h0001 << OMD_IO_I2C) |
                         (16'h0001 << OMD_IO_UART) |
                         (16'h0001 << OMD_IO_I2S) |
                         (16'h0001 << OMD_IO_SD) |
                         (16'h0001 << OMD_IO_USB) |
                         (16'h0001 << OMD_IO_MISC));
  end

endmodule

// [verification/omd_decoder_checker.sv]
// concurrent checks on the memory map decoder ports
`timescale 1ns/1ps
module omd_decoder_checker
  import omd_pkg::*;
#(
  parameter int NREQ = 2
)(
  input wire logic              mclk,
  input wire logic              rstn,
  input wire omd_pkg::omd_req_t req [NREQ],
  input wire logic              status_reg_3_wr,
  input wire logic              status_reg_3_rom_dis,
  input wire logic              soft_reset,
  input wire logic              boot_done,
  input wire logic              grant [NREQ],
  input wire omd_pkg::omd_sel_t sel [NREQ],
  input wire logic              rom_disable_bit,
  input wire logic              boot_active
);
  logic [4:0] blk;
  logic       cpu0;
  logic       cpu1;
  assign blk  = 5'(req[0].addr[18:13] - 6'h08);
  assign cpu0 = req[0].master inside {OMD_M_PROG, OMD_M_DATA};
  assign cpu1 = req[1].master inside {OMD_M_PROG, OMD_M_DATA};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);
  //////////////////////////////////////////////////////////////////////////
  sequence s_cpu_sar;
    req[0].valid && !req[0].io_space && cpu0 &&
      req[0].addr inside {[32'h10000:32'h4ffff]};
  endsequence
  sequence s_clash;
    s_cpu_sar ##0 req[1].valid && !req[1].io_space && cpu1 &&
      req[1].addr[31:13] == req[0].addr[31:13];
  endsequence
  a_one_target: assert property (grant[0] |-> $onehot(sel[0]))
    else $error("select not one-hot");
  a_idle_quiet: assert property (!grant[0] |-> sel[0] == '0)
    else $error("select without grant");
  a_rom_off: assert property (grant[0] && rom_disable_bit &&
    $past(rom_disable_bit, 2) |-> sel[0].rom_sel == '0)
    else $error("rom selected while disabled");
  a_rst_clear: assert property ($rose(rstn) |-> !rom_disable_bit)
    else $error("rom disable set after reset");
  a_soft_keep: assert property (soft_reset && !$past(status_reg_3_wr)
    |=> $stable(rom_disable_bit))
    else $error("soft reset moved rom disable");
  a_wr_load: assert property (status_reg_3_wr |-> ##2
    rom_disable_bit == $past(status_reg_3_rom_dis, 2))
    else $error("rom disable not loaded");
  a_sar_block: assert property (s_cpu_sar |=> !grant[0] ||
    sel[0].sar_sel == 32'h1 << $past(blk))
    else $error("wrong ram block");
  a_pair_serial: assert property (s_clash |=> grant[0] != grant[1])
    else $error("block clash not serialised");
  a_lone_grant: assert property (req[0].valid && !req[1].valid
    |=> grant[0])
    else $error("lone request not granted");
endmodule

bind omd_decoder omd_decoder_checker #(.NREQ(NREQ)) chk_i (
  .mclk(mclk), .rstn(rstn), .req(req),
  .status_reg_3_wr(status_reg_3_wr),
  .status_reg_3_rom_dis(status_reg_3_rom_dis), .soft_reset(soft_reset),
  .boot_done(boot_done), .grant(grant), .sel(sel),
  .rom_disable_bit(rom_disable_bit), .boot_active(boot_active));

// [verification/omd_master_model.sv]
// bus master model: presents one access request per requester
`timescale 1ns/1ps
module omd_master_model
  import omd_pkg::*;
#(
  parameter int NREQ = 2
)(
  input  wire logic         mclk,
  output omd_pkg::omd_req_t req [NREQ]
);
  initial foreach (req[i]) req[i] = '0;
  // reserved i/o holes are aimed at only when the bench asks for them
  // peripherals are taken as already out of reset and clocked
  task automatic put(input int i, input omd_master_t m, input logic io,
                     input logic [31:0] a);
    req[i] = '{1'b1, m, io, 1'($urandom), a};
  endtask
  // a released request shows no stale address
  task automatic drop(input int i);
    req[i].valid = 1'b0;
    req[i].addr  = ~req[i].addr;
  endtask
endmodule

// [verification/onchip_memory_map_decoder_test.sv]
// self-checking bench for the memory map decoder
`timescale 1ns/1ps
module onchip_memory_map_decoder_test;
  import omd_pkg::*;
  logic     mclk, rstn, soft_reset, boot_done;
  logic     status_reg_3_wr, status_reg_3_rom_dis;
  omd_req_t req [2];
  logic     grant [2];
  omd_sel_t sel [2];
  logic     rom_disable_bit, boot_active;
  int       n_fail, cmp_count;
  bit       dis_m, boot_m;
  int       io_a [] = '{'h0002, 'h0c00, 'h0d00, 'h0e00, 'h0f7f, 'h0c80,
    'h1800, 'h1840, 'h1880, 'h1820, 'h1900, 'h1a6c, 'h1a6d, 'h1b00,
    'h1c05, 'h2800, 'h2900, 'h3a00, 'h3b7f, 'h3a80, 'h8000, 'hffff,
    'h7000, 'h3000, 'h2e00, 'h0005};
  int       io_x [] = '{0, 1, 2, 3, 4, -1, 5, 6, 7, -1, 8, 9, -1, 10,
    11, 12, 12, 13, 13, -1, 14, 14, 15, 15, 15, -1};
  int       base_a [6] = '{'h0, 'h10000, 'h30000, 'h90000, 'hb0000,
    'hfe0000};
  omd_decoder #(.NREQ(2)) omd_decoder_i (.mclk(mclk), .rstn(rstn),
    .req(req), .status_reg_3_wr(status_reg_3_wr),
    .status_reg_3_rom_dis(status_reg_3_rom_dis),
    .soft_reset(soft_reset), .boot_done(boot_done), .grant(grant),
    .sel(sel), .rom_disable_bit(rom_disable_bit),
    .boot_active(boot_active));
  omd_master_model #(.NREQ(2)) omd_master_model_i (.mclk(mclk),
    .req(req));
  initial begin
    mclk = 0;
    forever #2 mclk = ~mclk;
  end
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input bit ok, input string m);
    cmp_count++;
    if (!ok) begin
      n_fail++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic final_report;
    if (n_fail == 0 && cmp_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // memory-space expectation from the address windows
  function automatic omd_sel_t model(omd_master_t m, int a);
    omd_sel_t s;
    bit       cpu;
    int       b;
    s = '0;
    cpu = m inside {OMD_M_PROG, OMD_M_DATA};
    b = (a - (cpu ? 'h10000 : 'h90000)) >>> 13;
    if (cpu && a >= 'h10000 && a <= 'h4ffff) s.sar_sel[b] = 1;
    else if (!cpu && a >= 'h90000 && a <= 'hcffff && !(b == 31 && boot_m))
      s.sar_sel[b] = 1;
    else if (cpu && a >= 'hfe0000 && a <= 'hffffff && !dis_m)
      s.rom_sel[(a - 'hfe0000) >> 15] = 1;
    else if (cpu ? a <= 'hffff : (m == OMD_M_DMA && a >= 'h10000 &&
      a <= 'h1ffff)) s.dar_sel = 1;
    else s.unmapped = 1;
    return s;
  endfunction
  task automatic acc(input omd_master_t m, input logic io,
                     input logic [31:0] a, input int iox = -1);
    omd_sel_t e;
    @(posedge mclk);
    #1;
    omd_master_model_i.put(0, m, io, a);
    e = model(m, a);
    if (io) begin
      e = '0;
      if (iox < 0) e.unmapped = 1;
      else e.io_sel[iox] = 1;
    end
    @(posedge mclk);
    #1;
    chk(grant[0] === 1'b1 && sel[0] === e, "select mismatch");
    omd_master_model_i.drop(0);
  endtask
  task automatic pair(input logic [31:0] a0, input logic [31:0] a1,
                      input int n);
    @(posedge mclk);
    #1;
    omd_master_model_i.put(0, OMD_M_PROG, 0, a0);
    omd_master_model_i.put(1, OMD_M_DATA, 0, a1);
    @(posedge mclk);
    #1;
    chk(int'(grant[0] === 1'b1) + int'(grant[1] === 1'b1) == n, "grants");
    chk(grant[1] === 1'b1 ? sel[1] === model(OMD_M_DATA, a1)
                          : sel[1] === '0, "second select");
    omd_master_model_i.drop(0);
    omd_master_model_i.drop(1);
  endtask
  task automatic pulse(ref logic s);
    @(posedge mclk);
    #1 s = 1;
    @(posedge mclk);
    #1 s = 0;
    repeat (3) @(posedge mclk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    n_fail++;
    final_report();
  end
  initial begin
    int k;
    void'($urandom(32'hf7d7087b));
    {rstn, status_reg_3_wr, status_reg_3_rom_dis, soft_reset, boot_done} = '0;
    boot_m = 1;
    repeat (8) @(posedge mclk);
    #1 rstn = 1;
    chk(rom_disable_bit === 1'b0 && boot_active === 1'b1, "reset");
    for (k = 0; k < 8; k++)
      acc(k[0] ? OMD_M_DATA : OMD_M_PROG, 0, 'hfe0000 + (k % 4) * 'h8000
        + $urandom_range(0, 'h7fff));
    acc(OMD_M_DMA, 0, 'hfe0000);
    for (k = 0; k < 32; k++) begin
      acc(OMD_M_PROG, 0, 'h10000 + k * 'h2000);
      acc(k[0] ? OMD_M_DMA : OMD_M_USB, 0,
        'h91fff + k * 'h2000);
    end
    acc(OMD_M_PROG, 0, 'h4e000);
    acc(OMD_M_USB, 0, 'h12000);
    acc(OMD_M_DMA, 0, 'h12000);
    foreach (io_a[i]) begin
      acc(OMD_M_PROG, 1, io_a[i], io_x[i]);
      acc(OMD_M_DMA, 1, io_a[i], io_x[i] inside {9, 10, 12, 13, 14, 15}
        ? io_x[i] : -1);
    end
    pulse(boot_done);
    boot_m = 0;
    chk(boot_active === 1'b0, "boot hold kept");
    acc(OMD_M_DMA, 0, 'hce000);
    pair('h10000, 'h11ffe, 1);
    pair('h10000, 'h12000, 2);
    pair('h2000, 'h2002, 2);
    repeat (40)
      acc(omd_master_t'(4'h1 << $urandom_range(0, 3)), 0,
        base_a[$urandom_range(0, 5)] + $urandom_range(0, 'h1ffff));
    status_reg_3_rom_dis = 1;
    pulse(status_reg_3_wr);
    dis_m = 1;
    chk(rom_disable_bit === 1'b1, "rom still enabled");
    acc(OMD_M_PROG, 0, 'hff0000);
    pulse(soft_reset);
    boot_m = 1;
    chk(rom_disable_bit === 1'b1 && boot_active === 1'b1, "soft");
    acc(OMD_M_DMA, 0, 'hcfffe);
    rstn = 0;
    repeat (2) @(posedge mclk);
    #1 rstn = 1;
    dis_m = 0;
    chk(rom_disable_bit === 1'b0, "reset kept disable");
    acc(OMD_M_PROG, 0, 'hfe0000);
    final_report();
  end
endmodule
